//--- include/strap_pkg.sv
// Shared types and constants for strap sampling and shared-pin selection
package strap_pkg;

  // Number of downstream over-current inputs
  localparam int unsigned PORT_COUNT = 4;

  // Values after reset of the latched straps
  localparam logic STRAP_SERIAL_RESET = 1'b1;
  localparam logic STRAP_FULL_PWR_N_RESET = 1'b1;

  // Strap encodings
  localparam logic SERIAL_MODE_I2C = 1'b1;
  localparam logic SERIAL_MODE_SMBUS = 1'b0;
  localparam logic FULL_PWR_ENABLED = 1'b0;

  // Serial controller request from the I2C master core
  typedef struct packed {
    logic scl_drive_low;
    logic sda_drive_low;
  } serial_drive_t;

  // Sampled straps after reset
  typedef struct packed {
    logic i2c_mode;
    logic power_switching_on;
    logic smbus_addr_bit1;
  } strap_cfg_t;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_SAMPLE,
    ST_RUN
  } strap_state_t;

endpackage

//--- hw/hub_strap_and_shared_pin_control.sv
// Strap sampling, over-current combining and shared serial pin selection
// Operation
// - Port 4 over-current input is active low
// - Ganged mode: any over-current input trips all
// - Serial strap sampled at reset release: 1=I2C
// - I2C mode: drive pins as EEPROM controller
// - SMBus mode: target, host drives clock
// - Status enable: serial pin shows suspend
// - Full-power strap sampled at reset release
// - Full-power strap low enables switching, over-current
// - SMBus address bit 1 from full-power strap
// - Status enable: full-power pin shows SuperSpeed connection
`timescale 1ns/100ps
module hub_strap_and_shared_pin_control (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Over-current pins and mode
  input wire logic [strap_pkg::PORT_COUNT-1:0] port_overcurrent_n_i,
  input wire logic ganged_mode_i,
  output logic [strap_pkg::PORT_COUNT-1:0] port_overcurrent_o,
  // Strap pins as three signals
  input wire logic serial_mode_strap_i,
  output logic serial_mode_strap_o,
  output logic serial_mode_strap_oe_o,
  input wire logic full_power_mgmt_strap_n_i,
  output logic full_power_mgmt_strap_n_o,
  output logic full_power_mgmt_strap_n_oe_o,
  // Status sources and enable
  input wire logic status_output_enable_i,
  input wire logic ss_suspended_i,
  input wire logic ss_connected_i,
  // Shared serial pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // I2C master core and SMBus target core
  input wire strap_pkg::serial_drive_t master_drive_i,
  input wire logic target_sda_low_i,
  output logic master_scl_o,
  output logic master_sda_o,
  output logic target_scl_o,
  output logic target_sda_o,
  // Latched configuration
  output strap_pkg::strap_cfg_t strap_cfg_o
);
  import strap_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  // The chain is not reset so that it keeps tracking the strap pins during
  // reset: the capture two edges after release then sees settled pin levels,
  // not a reset fill. Straps must hold until the last edge before release.
  localparam int unsigned SYNC_W = PORT_COUNT + 4;

  wire logic [SYNC_W-1:0] raw_in = {port_overcurrent_n_i,
                                    serial_mode_strap_i,
                                    full_power_mgmt_strap_n_i,
                                    scl_i,
                                    sda_i};

  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;

  always_ff @(posedge clk_i) begin
    sync1_q <= raw_in;
  end

  // Only this stage reads the first one
  always_ff @(posedge clk_i) begin
    sync2_q <= sync1_q;
  end

  wire logic [PORT_COUNT-1:0] oc_n_s = sync2_q[SYNC_W-1:4];
  wire logic serial_strap_s = sync2_q[3];
  wire logic full_pwr_strap_s = sync2_q[2];
  wire logic scl_s = sync2_q[1];
  wire logic sda_s = sync2_q[0];

  // ****************************************
  // Capture sequencer
  // ****************************************
  strap_state_t state_q;
  strap_state_t state_d;

  always_comb begin
    case (state_q)
      ST_RESET: begin
        state_d = ST_SAMPLE;
      end
      ST_SAMPLE: begin
        state_d = ST_RUN;
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // One capture per reset; RUN is terminal, so no later edge reloads the straps
  wire logic capture = (state_q == ST_SAMPLE);
  wire logic running = (state_q == ST_RUN);

  // ****************************************
  // Strap latches
  // ****************************************
  logic serial_strap_q;
  logic serial_strap_d;
  logic full_pwr_n_q;
  logic full_pwr_n_d;

  // Outside the capture cycle the latches feed back on themselves
  assign serial_strap_d = capture ? serial_strap_s : serial_strap_q;
  assign full_pwr_n_d = capture ? full_pwr_strap_s : full_pwr_n_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_strap_q <= STRAP_SERIAL_RESET;
    end else begin
      serial_strap_q <= serial_strap_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      full_pwr_n_q <= STRAP_FULL_PWR_N_RESET;
    end else begin
      full_pwr_n_q <= full_pwr_n_d;
    end
  end

  wire logic i2c_mode = (serial_strap_q == SERIAL_MODE_I2C);
  wire logic pwr_on = (full_pwr_n_q == FULL_PWR_ENABLED);
  // Reads 0 in I2C mode, where the hub has no target address
  wire logic smbus_addr_bit1 = full_pwr_n_q & ~i2c_mode;

  assign strap_cfg_o = '{
    i2c_mode: i2c_mode,
    power_switching_on: pwr_on,
    smbus_addr_bit1: smbus_addr_bit1
  };

  // ****************************************
  // Over-current
  // ****************************************
  // Pins arrive active low; bit 3 is port 4
  wire logic [PORT_COUNT-1:0] oc_raw = ~oc_n_s;
  // Ganged: every input is ORed in, so any one trips the gang and unused inputs must be held high
  wire logic oc_any = |oc_raw;
  logic [PORT_COUNT-1:0] oc_d;
  logic [PORT_COUNT-1:0] oc_q;

  for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
    wire logic oc_sel = ganged_mode_i ? oc_any : oc_raw[p];
    // With power switching strapped off the inputs are ignored
    assign oc_d[p] = pwr_on & oc_sel;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oc_q <= '0;
    end else begin
      oc_q <= oc_d;
    end
  end

  assign port_overcurrent_o = oc_q;

  // ****************************************
  // Strap pins as status outputs
  // ****************************************
  logic ss_susp_q;
  logic ss_conn_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ss_susp_q <= 1'b0;
    end else begin
      ss_susp_q <= ss_suspended_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ss_conn_q <= 1'b0;
    end else begin
      ss_conn_q <= ss_connected_i;
    end
  end

  // Pins stay inputs until the strap has been caught, else the capture would read our own drive
  wire logic status_drive = running & status_output_enable_i;

  assign serial_mode_strap_oe_o = status_drive;
  assign serial_mode_strap_o = ss_susp_q;
  assign full_power_mgmt_strap_n_oe_o = status_drive;
  assign full_power_mgmt_strap_n_o = ss_conn_q;

  // ****************************************
  // Shared serial pins
  // ****************************************
  // Open drain: the pads only pull low, the bus pull-ups give the high level.
  // The clock is never driven in SMBus mode, where the external host owns it.
  wire logic master_owns_bus = running & i2c_mode;
  wire logic target_owns_bus = running & ~i2c_mode;

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = master_owns_bus & master_drive_i.scl_drive_low;
  assign sda_oe_o = (master_owns_bus & master_drive_i.sda_drive_low)
                  | (target_owns_bus & target_sda_low_i);

  // The idle core sees a released bus
  assign master_scl_o = i2c_mode ? scl_s : 1'b1;
  assign master_sda_o = i2c_mode ? sda_s : 1'b1;
  assign target_scl_o = i2c_mode ? 1'b1 : scl_s;
  assign target_sda_o = i2c_mode ? 1'b1 : sda_s;

endmodule

//--- testbench/hub_strap_props.sv
// Port assertions for strap and shared-pin control
`timescale 1ns/100ps
module hub_strap_props (
  // Watched ports
  input wire logic clk_i, rst_i, ganged_mode_i, serial_mode_strap_o, ss_suspended_i,
  input wire logic scl_oe_o, sda_oe_o, target_sda_low_i,
  input wire logic [3:0] port_overcurrent_n_i, port_overcurrent_o,
  input wire strap_pkg::serial_drive_t master_drive_i,
  input wire strap_pkg::strap_cfg_t strap_cfg_o
);
  import strap_pkg::*;
  logic [1:0] n_q;
  wire run = &n_q;
  wire on = strap_cfg_o.power_switching_on;
  wire i2c = strap_cfg_o.i2c_mode;
  // Straps land two edges after release, so checks wait for the third
  always_ff @(posedge clk_i) n_q <= rst_i ? 2'h0 : n_q + {1'b0, !run};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  strap_hold_a: assert property (run |=> $stable(strap_cfg_o)) else $error("hold");
  oc_single_a: assert property (run && on && !ganged_mode_i |->
    port_overcurrent_o[3] == !$past(port_overcurrent_n_i[3], 3)) else $error("port4");
  oc_gang_a: assert property (run && on && ganged_mode_i |->
    port_overcurrent_o == {4{!(&$past(port_overcurrent_n_i, 3))}}) else $error("gang");
  oc_masked_a: assert property (run && !on |-> port_overcurrent_o == 4'h0) else $error("mask");
  i2c_drive_a: assert property (run && i2c |-> {scl_oe_o, sda_oe_o} == master_drive_i) else $error("i2c");
  smb_target_a: assert property (run && !i2c |-> !scl_oe_o && sda_oe_o == target_sda_low_i) else $error("smb");
  smb_addr_a: assert property (run && !i2c |-> strap_cfg_o.smbus_addr_bit1 != on) else $error("addr");
  suspend_out_a: assert property (run |-> serial_mode_strap_o == $past(ss_suspended_i)) else $error("susp");
endmodule

//--- testbench/strap_partner.sv
// Far side: strap resistors, pulled-up serial bus and SMBus host
`timescale 1ns/100ps
module strap_partner (
  input wire logic [1:0] strap_lvl_i,
  input wire logic host_scl_low_i, scl_oe_o, sda_oe_o, serial_mode_strap_o, serial_mode_strap_oe_o,
  input wire logic full_power_mgmt_strap_n_o, full_power_mgmt_strap_n_oe_o,
  output logic serial_mode_strap_i, full_power_mgmt_strap_n_i, scl_i, sda_i
);
  // Resistor level shows while the hub leaves a strap pin undriven
  assign serial_mode_strap_i = serial_mode_strap_oe_o ? serial_mode_strap_o : strap_lvl_i[1];
  assign full_power_mgmt_strap_n_i = full_power_mgmt_strap_n_oe_o ? full_power_mgmt_strap_n_o : strap_lvl_i[0];
  assign scl_i = !(scl_oe_o || host_scl_low_i);
  assign sda_i = !sda_oe_o;
endmodule

//--- testbench/hub_strap_and_shared_pin_control_tb_top.sv
// Directed bench for strap and shared-pin control
`timescale 1ns/100ps
module hub_strap_and_shared_pin_control_tb_top;
  import strap_pkg::*;
  logic clk_i = 0, rst_i = 1, ganged_mode_i = 0, status_output_enable_i = 0, ss_suspended_i = 0, ss_connected_i = 0;
  logic target_sda_low_i = 0, host_scl_low_i = 0, scl_o, sda_o, master_scl_o, master_sda_o, target_scl_o, target_sda_o;
  logic serial_mode_strap_i, serial_mode_strap_o, serial_mode_strap_oe_o, scl_i, scl_oe_o, sda_i, sda_oe_o;
  logic full_power_mgmt_strap_n_i, full_power_mgmt_strap_n_o, full_power_mgmt_strap_n_oe_o;
  logic [3:0] port_overcurrent_n_i = 4'hF, port_overcurrent_o;
  logic [1:0] strap_lvl_i = 2'h3;
  serial_drive_t master_drive_i = '0;
  strap_cfg_t strap_cfg_o;
  int n_errors = 0, n_checks = 0;
  always #2.5 clk_i = ~clk_i;
  hub_strap_and_shared_pin_control i_hub_strap_and_shared_pin_control (.*);
  strap_partner i_strap_partner (.*);
  task automatic cyc(int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  // Strap pins flip after release to show the latch ignores them
  task automatic boot(logic [1:0] l);
    strap_lvl_i = l;
    status_output_enable_i = 0;
    rst_i = 1;
    cyc(20);
    rst_i = 0;
    cyc(5);
    strap_lvl_i = ~l;
  endtask
  task automatic i2c_case;
    boot(2'h2);
    chk("cfg", 8'(strap_cfg_o), 8'h6);
    master_drive_i = 2'h2;
    cyc(1);
    chk("bus", 8'({scl_i, sda_i}), 8'h1);
    cyc(2);
    chk("core", 8'({scl_o, sda_o, master_scl_o, master_sda_o, target_scl_o, target_sda_o}), 8'h07);
    master_drive_i = 2'h0;
    port_overcurrent_n_i = 4'h7;
    cyc(4);
    chk("oc", 8'(port_overcurrent_o), 8'h8);
    port_overcurrent_n_i = 4'hF;
    cyc(4);
    ganged_mode_i = 1;
    port_overcurrent_n_i = 4'hE;
    cyc(4);
    chk("gang", 8'(port_overcurrent_o), 8'hF);
    port_overcurrent_n_i = 4'hF;
    status_output_enable_i = 1;
    ss_suspended_i = 1;
    cyc(2);
    chk("sts", 8'({serial_mode_strap_i, full_power_mgmt_strap_n_i, strap_cfg_o}), 8'h16);
    ss_suspended_i = 0;
    ss_connected_i = 1;
    cyc(2);
    chk("sts2", 8'({serial_mode_strap_i, full_power_mgmt_strap_n_i, strap_cfg_o}), 8'h0E);
  endtask
  task automatic smbus_case;
    boot(2'h1);
    chk("cfg", 8'(strap_cfg_o), 8'h1);
    master_drive_i = 2'h2;
    host_scl_low_i = 1;
    target_sda_low_i = 1;
    port_overcurrent_n_i = 4'h0;
    cyc(4);
    chk("smb", {scl_oe_o, sda_i, target_scl_o, master_sda_o, port_overcurrent_o}, 8'h10);
    chk("smbcore", 8'({master_scl_o, target_sda_o}), 8'h2);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    i2c_case();
    smbus_case();
    report_and_stop();
  end
  // Both cases need well under 100 cycles
  initial begin
    #2000;
    n_errors++;
    report_and_stop();
  end
endmodule
bind hub_strap_and_shared_pin_control hub_strap_props i_hub_strap_props (.*);
